// ### pkg/fcdj_params.svh
// Purpose: constants for the file/jump execution slice
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes:   definitions only
`ifndef FCDJ_PARAMS_SVH
`define FCDJ_PARAMS_SVH

// ----------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------
`define OPC_COMPLEMENT   6'h09
`define OPC_DECREMENT   6'h03
`define OPC_DEC_SKIP    6'h0B
`define OPC_JUMP        3'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DEST_BIT        7
`define LATCH_HI_BIT    4
`define LATCH_LO_BIT    3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PC_RESET        13'h0000

`endif

// ### pkg/fcdj_pkg.sv
// Purpose: types for the file/jump execution slice
// Assumes: nothing beyond the constants header
// Notes:   no constants here, see the params header
package fcdj_pkg;

    // ------------------------------------------------------------
    // decoded operation
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE = 5'h01,
        OP_COMP = 5'h02,
        OP_DEC  = 5'h04,
        OP_DSZ  = 5'h08,
        OP_JMP  = 5'h10
    } op_t;

    // file register write request
    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_t;

endpackage

// ### logic/file_complement_decrement_jump.sv
// Purpose: executes complement, decrement, decrement-skip and jump
// Assumes: file read data is combinational from instr_i[6:0]
// Notes:   other opcodes write no file, W or flag result; the PC still increments
`timescale 1ns/1ps
`default_nettype none
`include "fcdj_params.svh"

module file_complement_decrement_jump
    import fcdj_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [13:0] instr_i,
    input  wire logic [7:0]  file_rdata_i,
    input  wire logic [7:0]  pc_upper_latch_i,
    output logic      [6:0]  file_addr_o,
    output file_wr_t         file_wr_o,
    output logic             w_we_o,
    output logic      [7:0]  w_data_o,
    output logic             zero_we_o,
    output logic             zero_o,
    output logic      [12:0] pc_o,
    output logic             flush_o,
    output logic             busy_o
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    op_t        op;
    logic       dest;
    logic [7:0] result;
    logic       flush_q;

    // a flushed slot decodes as no_operation
    always_comb begin
        op = OP_NONE;
        if (!flush_q) begin
            if (instr_i[13:8] == `OPC_COMPLEMENT) begin
                op = OP_COMP;
            end else if (instr_i[13:8] == `OPC_DECREMENT) begin
                op = OP_DEC;
            end else if (instr_i[13:8] == `OPC_DEC_SKIP) begin
                op = OP_DSZ;
            end else if (instr_i[13:11] == `OPC_JUMP) begin
                op = OP_JMP;
            end
        end
    end

    assign dest = instr_i[`DEST_BIT];

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    // inverse or decrement of file
    always_comb begin
        case (op)
            OP_COMP: result = ~file_rdata_i;
            OP_DEC:  result = file_rdata_i - 8'h01;
            OP_DSZ:  result = file_rdata_i - 8'h01;
            default: result = 8'h00;
        endcase
    end

    // registered copy for observers; reads must use instr_i directly
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            file_addr_o <= 7'h00;
        end else begin
            file_addr_o <= instr_i[6:0];
        end
    end

    // ------------------------------------------------------------
    // result routing, registered writes
    // ------------------------------------------------------------
    // destination select
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            file_wr_o <= '0;
            w_we_o    <= 1'b0;
            w_data_o  <= 8'h00;
        end else begin
            file_wr_o.we   <= (op == OP_COMP || op == OP_DEC ||
                               op == OP_DSZ) && dest;
            file_wr_o.addr <= instr_i[6:0];
            file_wr_o.data <= result;
            w_we_o         <= (op == OP_COMP || op == OP_DEC ||
                               op == OP_DSZ) && !dest;
            w_data_o       <= result;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            zero_we_o <= 1'b0;
            zero_o    <= 1'b0;
        end else begin
            zero_we_o <= (op == OP_COMP) || (op == OP_DEC);
            zero_o    <= (result == 8'h00);
        end
    end

    // ------------------------------------------------------------
    // program counter and flush
    // ------------------------------------------------------------
    logic skip_zero;
    assign skip_zero = (op == OP_DSZ) && (result == 8'h00);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_o <= `PC_RESET;
        end else if (op == OP_JMP) begin
            pc_o <= {pc_upper_latch_i[`LATCH_HI_BIT:`LATCH_LO_BIT],
                     instr_i[10:0]};
        end else begin
            pc_o <= pc_o + 13'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= skip_zero || (op == OP_JMP);
        end
    end

    assign flush_o = flush_q;
    assign busy_o  = flush_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_jump;
        op == OP_JMP;
    endsequence

    a_jump_low_bits: assert property (@(posedge clk_i)
        disable iff (!resetn_i) s_jump |=> pc_o[10:0] == $past(instr_i[10:0]))
        else $error("jump target not loaded");
    a_jump_high_bits: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        s_jump |=> pc_o[12:11] == $past(pc_upper_latch_i[4:3]))
        else $error("jump upper bits wrong");
    a_jump_flush: assert property (@(posedge clk_i)
        disable iff (!resetn_i) s_jump |=> flush_o ##1 !flush_o)
        else $error("jump flush not one cycle");
    a_skip_flush: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_DSZ) |=>
        flush_o == ($past(file_rdata_i) == 8'h01))
        else $error("skip flush mismatch");
    a_skip_no_flag: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_DSZ) |=> !zero_we_o)
        else $error("skip touched flags");
    a_comp_value: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_COMP) |=>
        w_data_o == ~$past(file_rdata_i))
        else $error("complement value wrong");
    a_dest_route: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_COMP) |=>
        file_wr_o.we == $past(dest) && w_we_o == !$past(dest))
        else $error("destination routing wrong");
    a_dec_zero: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_DEC) |=>
        zero_we_o && zero_o == ($past(file_rdata_i) == 8'h01))
        else $error("decrement zero flag wrong");
    a_comp_zero: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_COMP) |=>
        zero_o == ($past(file_rdata_i) == 8'hFF))
        else $error("complement zero flag wrong");
    a_single_cycle: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_DEC || op == OP_COMP) |=> !flush_o)
        else $error("file op flushed");
    a_skip_cycles: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_DSZ && result != 8'h00) |=> !busy_o)
        else $error("non-skip took two cycles");
    a_jump_no_flag: assert property (@(posedge clk_i)
        disable iff (!resetn_i) s_jump |=> !zero_we_o)
        else $error("jump touched flags");

    // a taken skip is the op slot plus one dead slot
    sequence s_skip_taken;
        op == OP_DSZ && result == 8'h00;
    endsequence

    sequence s_dead_slot;
        flush_o && op == OP_NONE;
    endsequence

    a_skip_two_cycles: assert property (@(posedge clk_i)
        disable iff (!resetn_i) s_skip_taken |=> s_dead_slot ##1 !flush_o)
        else $error("taken skip not two cycles");
    a_dead_slot_quiet: assert property (@(posedge clk_i)
        disable iff (!resetn_i) s_dead_slot |=>
        !file_wr_o.we && !w_we_o && !zero_we_o)
        else $error("discarded slot wrote a result");
    a_dec_value: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_DEC || op == OP_DSZ) |=>
        w_data_o == $past(file_rdata_i) - 8'h01)
        else $error("decrement value wrong");
    a_dec_route: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_DEC || op == OP_DSZ) |=>
        file_wr_o.we == $past(dest) && w_we_o == !$past(dest))
        else $error("decrement routing wrong");
    a_write_addr: assert property (@(posedge clk_i)
        disable iff (!resetn_i) (op == OP_COMP && dest) |=>
        file_wr_o.we && file_wr_o.addr == $past(instr_i[6:0]))
        else $error("file write address wrong");
    a_jump_no_write: assert property (@(posedge clk_i)
        disable iff (!resetn_i) s_jump |=> !file_wr_o.we && !w_we_o)
        else $error("jump wrote a result");

endmodule
`default_nettype wire

// ### bench/file_complement_decrement_jump_tb.sv
// Purpose: self-checking bench for the file/jump execution slice
// Assumes: results show just after the edge that samples the op
// Notes:   driver queues expected results, a monitor pops and compares
`timescale 1ns/1ps
`default_nettype none
`include "fcdj_params.svh"

module file_complement_decrement_jump_tb
    import fcdj_pkg::*;
;
    logic        clk_i;
    logic        resetn_i;
    logic [13:0] instr_i;
    logic [7:0]  file_rdata_i;
    logic [7:0]  pc_upper_latch_i;
    file_wr_t    file_wr_o;
    logic        w_we_o;
    logic [7:0]  w_data_o;
    logic        zero_we_o;
    logic        zero_o;
    logic [12:0] pc_o;
    logic        flush_o;
    logic        busy_o;
    logic [6:0]  file_addr_o;
    logic [6:0]  a_e;
    logic [12:0] pc_e;
    logic [7:0]  w_q[$];
    logic [14:0] f_q[$];
    logic        z_q[$];
    logic [13:0] p_q[$];
    logic [13:0] pe;
    logic [31:0] seed;
    logic [31:0] r;
    logic [5:0]  opcs[5];
    logic        skip;
    int          err_total;
    int          n_tests;
    int          cycles;

    file_complement_decrement_jump dut_u (
        .clk_i(clk_i), .resetn_i(resetn_i), .instr_i(instr_i),
        .file_rdata_i(file_rdata_i), .pc_upper_latch_i(pc_upper_latch_i),
        .file_addr_o(file_addr_o), .file_wr_o(file_wr_o), .w_we_o(w_we_o),
        .w_data_o(w_data_o), .zero_we_o(zero_we_o), .zero_o(zero_o),
        .pc_o(pc_o), .flush_o(flush_o), .busy_o(busy_o));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic stop_test();
        $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // drive one slot; a flushed slot queues nothing
    task automatic op(input logic [13:0] ins, input logic [7:0] fd,
                      input logic [7:0] lat);
        logic [7:0] res;
        @(negedge clk_i);
        instr_i = ins;
        file_rdata_i = fd;
        pc_upper_latch_i = lat;
        res = (ins[13:8] == `OPC_COMPLEMENT) ? ~fd : fd - 8'h01;
        if (skip) begin
            skip = 1'b0;
        end else if (ins[13:11] == `OPC_JUMP) begin
            p_q.push_back({1'b1, lat[4:3], ins[10:0]});
            skip = 1'b1;
        end else if (ins[13:8] inside {`OPC_COMPLEMENT, `OPC_DECREMENT,
                                       `OPC_DEC_SKIP}) begin
            if (ins[`DEST_BIT]) f_q.push_back({ins[6:0], res});
            else w_q.push_back(res);
            if (ins[13:8] != `OPC_DEC_SKIP) begin
                z_q.push_back(res == 8'h00);
            end else if (res == 8'h00) begin
                p_q.push_back(14'h0000);
                skip = 1'b1;
            end
        end
    endtask

    // ----------------------------------------------------------------
    // clock, timeout and monitor
    // ----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // ceiling well above the ~260 cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            stop_test();
        end
    end

    // sample just after the edge so registered outputs have landed
    always @(posedge clk_i) begin
        a_e = instr_i[6:0];
        #1;
        if (resetn_i) begin
            if (w_we_o) chk(w_data_o, w_q.size() ? w_q.pop_front() : 8'hXX);
            if (file_wr_o.we) chk({file_wr_o.addr, file_wr_o.data},
                f_q.size() ? f_q.pop_front() : 15'hXXXX);
            if (zero_we_o) chk(zero_o, z_q.size() ? z_q.pop_front() : 1'bX);
            chk(file_addr_o, a_e);
            chk(flush_o, skip);
            chk(busy_o, skip);
            pe = 14'h0000;
            if (flush_o) begin
                pe = p_q.size() ? p_q.pop_front() : 14'hXXXX;
                if (pe[13] !== 1'b0) chk(pc_o, pe[12:0]);
            end
            pc_e = (pe[13] === 1'b1) ? pe[12:0] : pc_e + 13'h0001;
            chk(pc_o, pc_e);
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h0000AFE6;
        opcs = '{`OPC_COMPLEMENT, `OPC_DECREMENT, `OPC_DEC_SKIP, 6'h28, 6'h0A};
        {err_total, n_tests, cycles} = '0;
        skip = 1'b0;
        pc_e = 13'h0000;
        instr_i = 14'h0000;
        file_rdata_i = 8'h00;
        pc_upper_latch_i = 8'h00;
        resetn_i = 1'b0;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        resetn_i = 1'b1;
        op(14'h0913, 8'h13, 8'h00);
        op(14'h09C5, 8'hFF, 8'h00);
        op(14'h03FF, 8'h01, 8'h00);
        op(14'h0302, 8'h00, 8'h00);
        op(14'h0B11, 8'h02, 8'h00);
        op(14'h0BA2, 8'h01, 8'h00);
        op(14'h2ABC, 8'h00, 8'h18);
        op(14'h2FFF, 8'h00, 8'h18);
        op(14'h2800, 8'h00, 8'hF7);
        op(14'h2800, 8'h00, 8'hE7);
        // random mix with frequent zero results from decrements
        repeat (240) begin
            r = rnd();
            r[13:8] = opcs[r[18:16] % 5];
            if (r[13:11] == `OPC_JUMP) r[10:8] = r[22:20];
            op(r[13:0], r[24] ? 8'h01 : r[31:24], r[23:16]);
        end
        op(14'h0000, 8'h00, 8'h00);
        op(14'h0000, 8'h00, 8'h00);
        repeat (3) @(negedge clk_i);
        chk(16'(w_q.size() + f_q.size() + z_q.size() + p_q.size()),
            16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire
